// ===== dasp_pkg.sv
package dasp_pkg;

    // ----------------------------------------
    // Widths and timing
    // ----------------------------------------
    localparam int unsigned WORD_W         = 12;
    localparam int unsigned RAW_W          = 14;
    localparam int unsigned LATENCY        = 7;
    localparam int unsigned SEL_W          = 2;
    localparam real         CLK_PERIOD_NS  = 100.0;

    // ----------------------------------------
    // Code points, offset binary
    // ----------------------------------------
    localparam logic [WORD_W-1:0] CODE_MIN = 12'h000;
    localparam logic [WORD_W-1:0] CODE_MID = 12'h800;
    localparam logic [WORD_W-1:0] CODE_MAX = 12'hFFF;
    localparam int unsigned       MSB_POS  = WORD_W - 1;

    // Signed raw input limits (wider than a word so overrange is visible)
    localparam logic signed [RAW_W-1:0] RAW_MIN = -14'sd2048;
    localparam logic signed [RAW_W-1:0] RAW_MAX = 14'sd2047;

    // ----------------------------------------
    // Four-level select pin, as resolved by the pad
    // ----------------------------------------
    localparam logic [SEL_W-1:0] SEL_LOW   = 2'h0;
    localparam logic [SEL_W-1:0] SEL_MID   = 2'h1;
    localparam logic [SEL_W-1:0] SEL_FLOAT = 2'h2;
    localparam logic [SEL_W-1:0] SEL_HIGH  = 2'h3;

    typedef enum logic {
        DASP_FMT_OFFSET,
        DASP_FMT_TWOS
    } dasp_fmt_t;

    typedef struct packed {
        logic signed [RAW_W-1:0] chan_a;
        logic signed [RAW_W-1:0] chan_b;
    } dasp_raw_pair_t;

    typedef struct packed {
        logic [WORD_W-1:0] chan_a;
        logic [WORD_W-1:0] chan_b;
    } dasp_word_pair_t;

endpackage

// ===== dasp_formatter.sv
`timescale 1ns/100ps
`default_nettype none

module dasp_formatter
    import dasp_pkg::*;
(
    input  wire logic signed [RAW_W-1:0] raw,
    input  wire dasp_fmt_t               fmt,
    output logic             [WORD_W-1:0] word
);

    logic [WORD_W-1:0] offset_code;

    // ----------------------------------------
    // Clip then recode
    // ----------------------------------------
    always_comb begin
        // Saturate rather than wrap on overrange
        if (raw > RAW_MAX) begin
            offset_code = CODE_MAX;
        end else if (raw < RAW_MIN) begin
            offset_code = CODE_MIN;
        end else begin
            // Offset binary: midscale sits at the top bit
            offset_code = raw[WORD_W-1:0] ^ CODE_MID;
        end
        word = offset_code;
        if (fmt == DASP_FMT_TWOS) begin
            word[MSB_POS] = ~offset_code[MSB_POS];
        end
    end

endmodule
`default_nettype wire

// ===== dasp_pipeline.sv
// Notes on behaviour
// - Both channels sampled together each rising edge.
// - Output appears exactly seven cycles after sampling.
// - One new word per channel every cycle.
// - Each output word is twelve bits.
// - Select pin chooses offset binary or twos complement.
// - Offset binary: zero, midscale 800, full FFF.
// - Twos complement inverts offset binary top bit.
// - Overrange input clips to format limits.
// - Power-down high enters low power state.
// - Select decode: high, low, mid, floating.
// - Power-down loses pipeline contents, outputs cleared to zero.
`timescale 1ns/100ps
`default_nettype none

module dasp_pipeline
    import dasp_pkg::*;
(
    input  wire logic           core_clk,
    input  wire logic           sys_rst,
    input  wire dasp_raw_pair_t sample_in,
    input  wire logic [SEL_W-1:0] format_and_stabilizer_select,
    input  wire logic           low_power_request,
    output dasp_word_pair_t     word_out,
    output logic                word_valid,
    output logic                stabilizer_on,
    output logic                low_power_active
);

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    logic [SEL_W-1:0] sel_meta;
    logic [SEL_W-1:0] sel_sync;
    logic             pd_meta;
    logic             pd_sync;

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            sel_meta <= SEL_HIGH;
            sel_sync <= SEL_HIGH;
            pd_meta  <= 1'b0;
            pd_sync  <= 1'b0;
        end else begin
            sel_meta <= format_and_stabilizer_select;
            sel_sync <= sel_meta;
            pd_meta  <= low_power_request;
            pd_sync  <= pd_meta;
        end
    end

    // ----------------------------------------
    // Select decode
    // ----------------------------------------
    dasp_fmt_t fmt;
    logic      next_stab;

    always_comb begin
        unique case (sel_sync)
            SEL_HIGH: begin
                fmt       = DASP_FMT_OFFSET;
                next_stab = 1'b1;
            end
            SEL_LOW: begin
                fmt       = DASP_FMT_TWOS;
                next_stab = 1'b1;
            end
            SEL_MID: begin
                fmt       = DASP_FMT_TWOS;
                next_stab = 1'b0;
            end
            SEL_FLOAT: begin
                fmt       = DASP_FMT_OFFSET;
                next_stab = 1'b0;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            stabilizer_on <= 1'b1;
        end else begin
            stabilizer_on <= next_stab;
        end
    end

    // ----------------------------------------
    // Capture and format
    // ----------------------------------------
    // Format is applied at capture, so a select change shows after latency
    dasp_word_pair_t fmt_word;

    dasp_formatter u_fmt_a (
        .raw  (sample_in.chan_a),
        .fmt  (fmt),
        .word (fmt_word.chan_a)
    );

    dasp_formatter u_fmt_b (
        .raw  (sample_in.chan_b),
        .fmt  (fmt),
        .word (fmt_word.chan_b)
    );

    // ----------------------------------------
    // Delay line
    // ----------------------------------------
    dasp_word_pair_t stage [LATENCY];
    logic            stage_ok [LATENCY];

    always_ff @(posedge core_clk) begin
        if (sys_rst || pd_sync) begin
            stage[0]    <= '0;
            stage_ok[0] <= 1'b0;
        end else begin
            stage[0]    <= fmt_word;
            stage_ok[0] <= 1'b1;
        end
    end

    genvar gi;
    generate
        for (gi = 1; gi < LATENCY; gi++) begin : g_stage
            always_ff @(posedge core_clk) begin
                if (sys_rst || pd_sync) begin
                    stage[gi]    <= '0;
                    stage_ok[gi] <= 1'b0;
                end else begin
                    stage[gi]    <= stage[gi-1];
                    stage_ok[gi] <= stage_ok[gi-1];
                end
            end
        end
    endgenerate

    // Pins come from a flop, seventh edge after capture
    // Flushed with the delay line, so no stale word survives a wake
    always_ff @(posedge core_clk) begin
        if (sys_rst || pd_sync) begin
            word_out   <= '0;
            word_valid <= 1'b0;
        end else begin
            word_out   <= stage[LATENCY-1];
            word_valid <= stage_ok[LATENCY-1];
        end
    end

    // ----------------------------------------
    // Power state
    // ----------------------------------------
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            low_power_active <= 1'b0;
        end else begin
            low_power_active <= pd_sync;
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    // Capture edge is cycle zero; the output flop loads seven edges later
    property p_latency;
        @(posedge core_clk) disable iff (sys_rst || pd_sync)
        stage_ok[0] |-> ##7 (word_valid && word_out == $past(stage[0], 7));
    endproperty
    a_latency: assert property (p_latency) else $error("latency not seven");

    property p_capture;
        @(posedge core_clk) disable iff (sys_rst)
        !pd_sync |=> stage[0] == $past(fmt_word);
    endproperty
    a_capture: assert property (p_capture) else $error("sample not captured");

    property p_flush;
        @(posedge core_clk) disable iff (sys_rst)
        pd_sync |=> !word_valid;
    endproperty
    a_flush: assert property (p_flush) else $error("pipeline not flushed");

    property p_refill;
        @(posedge core_clk) disable iff (sys_rst)
        $fell(pd_sync) |-> !word_valid [*8];
    endproperty
    a_refill: assert property (p_refill) else $error("valid before refill");

    property p_power;
        @(posedge core_clk) disable iff (sys_rst)
        pd_sync |=> low_power_active;
    endproperty
    a_power: assert property (p_power) else $error("power state lag");

    property p_stream;
        @(posedge core_clk) disable iff (sys_rst || pd_sync)
        stage_ok[LATENCY-1] |=> word_valid;
    endproperty
    a_stream: assert property (p_stream) else $error("word missing");

    property p_twos;
        @(posedge core_clk) disable iff (sys_rst)
        (fmt == DASP_FMT_TWOS && sample_in.chan_b == RAW_MAX) |-> fmt_word.chan_b == 12'h7FF;
    endproperty
    a_twos: assert property (p_twos) else $error("twos max wrong");

    property p_midscale;
        @(posedge core_clk) disable iff (sys_rst)
        (fmt == DASP_FMT_OFFSET && sample_in.chan_a == '0) |-> fmt_word.chan_a == CODE_MID;
    endproperty
    a_midscale: assert property (p_midscale) else $error("midscale code wrong");

    property p_clip;
        @(posedge core_clk) disable iff (sys_rst)
        (fmt == DASP_FMT_OFFSET && sample_in.chan_b > RAW_MAX) |-> fmt_word.chan_b == CODE_MAX;
    endproperty
    a_clip: assert property (p_clip) else $error("no clip");

    property p_decode;
        @(posedge core_clk) disable iff (sys_rst)
        (sel_sync == SEL_MID) |-> (fmt == DASP_FMT_TWOS) ##1 !stabilizer_on;
    endproperty
    a_decode: assert property (p_decode) else $error("select decode");

endmodule
`default_nettype wire

// ===== dasp_capture.sv
`timescale 1ns/100ps
`default_nettype none

module dasp_capture
    import dasp_pkg::*;
(
    input  wire logic            core_clk,
    input  wire logic            sys_rst,
    input  wire dasp_word_pair_t word_out,
    input  wire logic            word_valid,
    input  wire logic            low_power_active,
    output logic                 trusted,
    output dasp_word_pair_t      held
);
    logic [3:0] since_wake;

    // Saturating count, so a long run never wraps into distrust
    always_ff @(posedge core_clk) begin
        if (sys_rst || low_power_active) begin
            since_wake <= 4'h0;
        end else if (since_wake != 4'hF) begin
            since_wake <= since_wake + 4'h1;
        end
    end

    assign trusted = word_valid && (since_wake >= 4'h7);

    always_ff @(posedge core_clk) begin
        if (trusted) begin
            held <= word_out;
        end
    end
endmodule

`default_nettype wire

// ===== dasp_pipeline_bench.sv
`timescale 1ns/100ps
`default_nettype none

module dasp_pipeline_bench;
    import dasp_pkg::*;

    logic            core_clk = 1'b0;
    logic            sys_rst = 1'b1;
    dasp_raw_pair_t  sample_in = '0;
    logic [SEL_W-1:0] sel = SEL_HIGH;
    logic            low_power_request = 1'b0;
    dasp_word_pair_t word_out;
    logic            word_valid;
    logic            stabilizer_on;
    logic            low_power_active;
    logic            trusted;
    dasp_word_pair_t held;
    int              n_fail = 0;
    int              n_checks = 0;

    always #(CLK_PERIOD_NS / 2.0) core_clk = ~core_clk;

    dasp_pipeline DUT (
        .core_clk                     (core_clk),
        .sys_rst                      (sys_rst),
        .sample_in                    (sample_in),
        .format_and_stabilizer_select (sel),
        .low_power_request            (low_power_request),
        .word_out                     (word_out),
        .word_valid                   (word_valid),
        .stabilizer_on                (stabilizer_on),
        .low_power_active             (low_power_active)
    );

    dasp_capture far_end (
        .core_clk         (core_clk),
        .sys_rst          (sys_rst),
        .word_out         (word_out),
        .word_valid       (word_valid),
        .low_power_active (low_power_active),
        .trusted          (trusted),
        .held             (held)
    );

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic complete_run();
        $display("checks %0d failures %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Clip first, then bias; twos form flips only the top bit
    function automatic logic [11:0] code(input int v, input logic twos);
        logic [11:0] c;
        v = (v < -2048) ? -2048 : ((v > 2047) ? 2047 : v);
        c = 12'(v) ^ 12'h800;
        return twos ? (c ^ 12'h800) : c;
    endfunction

    // One-cycle impulse on a quiet midscale stream
    task automatic pulse(input int a, input int b, input logic twos);
        sample_in = '0;
        repeat (8) @(negedge core_clk);
        sample_in = {14'(a), 14'(b)};
        @(negedge core_clk);
        sample_in = '0;
        repeat (6) @(negedge core_clk);
        chk(word_out, {2{code(0, twos)}});
        @(negedge core_clk);
        chk(word_out, {code(a, twos), code(b, twos)});
        chk({23'h0, word_valid}, 24'h1);
        @(negedge core_clk);
        chk(held, {code(a, twos), code(b, twos)});
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic formats();
        logic [SEL_W-1:0] s [4] = '{SEL_HIGH, SEL_LOW, SEL_MID, SEL_FLOAT};
        logic             tw [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
        logic             st [4] = '{1'b1, 1'b1, 1'b0, 1'b0};
        for (int i = 0; i < 4; i++) begin
            sel = s[i];
            repeat (4) @(negedge core_clk);
            chk({23'h0, stabilizer_on}, {23'h0, st[i]});
            pulse(-2048, 2047, tw[i]);
            pulse(-1024, 1024, tw[i]);
            pulse(-3000, 5000, tw[i]);
        end
    endtask

    task automatic power_down();
        int k;
        sel = SEL_HIGH;
        low_power_request = 1'b1;
        for (k = 0; k < 6 && low_power_active !== 1'b1; k++) @(negedge core_clk);
        if (k == 6) begin n_fail++; complete_run(); end
        repeat (2) @(negedge core_clk);
        chk({23'h0, word_valid}, 24'h0);
        low_power_request = 1'b0;
        for (k = 0; k < 20 && trusted !== 1'b1; k++) @(negedge core_clk);
        if (k == 20) begin n_fail++; complete_run(); end
        // Two sync flops, one edge to reopen capture, then the full latency
        chk(24'(k), 24'(LATENCY + 3));
        chk({23'h0, low_power_active}, 24'h0);
        pulse(2047, -2048, 1'b0);
    endtask

    initial begin
        repeat (2) @(negedge core_clk);
        sys_rst = 1'b0;
        chk({22'h0, word_valid, stabilizer_on}, 24'h1);
        formats();
        power_down();
        complete_run();
    end
endmodule

`default_nettype wire
